// *** inc/bwhp_consts.svh ***
// constants of the byte-wide codec host port
// Function
// - request capture while a sample waits
// - hold capture request until all bytes read
// - playback request until whole sample written
// - capture acknowledge read returns sample bytes
// - playback acknowledge write stores sample byte
// - register select picks the direct register
// - read strobe starts register or capture read
// - write strobe starts register or playback write
// - register cycles need chip select low
// - dma cycles ignore chip select
// - drive data bus only during reads
// - buffer enable low during qualified strobes
// - buffer direction low during qualified reads
// - interrupt on dma count underflow
// - external controls mirror register bits
// - power down shuts the port down
// - crystal select only mirrored to crystal b active flag
`ifndef BWHP_CONSTS_SVH
`define BWHP_CONSTS_SVH
`define BWHP_BYTE_W 8
`define BWHP_SEL_W 2
`define BWHP_EXT_W 2
`define BWHP_SAMPLE_W 32
`define BWHP_SAMPLE_BYTES 4
`define BWHP_BIDX_W 2
`define BWHP_BIDX_LAST 2'h3
`define BWHP_BIDX_ONE 2'h1
`define BWHP_BIDX_ZERO 2'h0
`define BWHP_FIFO_DEPTH 32
`define BWHP_BYTE_ZERO 8'h00
`define BWHP_SAMPLE_ZERO 32'h0000_0000
`define BWHP_EXT_ZERO 2'h0
`define BWHP_SEL_ZERO 2'h0
`define BWHP_CRYSTAL_A_HZ 24576000
`define BWHP_CRYSTAL_B_HZ 16934400
`define BWHP_CLOCK_HZ 125000000
`endif

// *** inc/bwhp_pkg.sv ***
// types of the byte-wide codec host port
package bwhp_pkg;
  // host pins as sampled together
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic capture_ack_n;
    logic playback_ack_n;
    logic [1:0] register_select;
    logic [7:0] data;
  } bwhp_pins_t;

  typedef enum logic [2:0] {
    CYC_IDLE = 3'b000,
    CYC_REG_RD = 3'b001,
    CYC_REG_WR = 3'b010,
    CYC_CAP_RD = 3'b011,
    CYC_PLAY_WR = 3'b100
  } bwhp_cycle_t;
endpackage : bwhp_pkg

// *** hdl/bwhp_host_port.sv ***
// host port logic and its capture fifo
`timescale 1ns/10ps
`include "bwhp_consts.svh"

module bwhp_fifo #(
  parameter int WIDTH = `BWHP_SAMPLE_W,
  parameter int DEPTH = `BWHP_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_C = (AW+1)'(1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = count_q + ONE_C;
    end
    else if (pop && !push)
    begin
      count_d = count_q - ONE_C;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= AW'(wr_ptr_q + AW'(1));
      end
      if (pop)
      begin
        rd_ptr_q <= AW'(rd_ptr_q + AW'(1));
      end
      count_q <= count_d;
      in_ready <= (count_d != DEPTH_C);
      out_valid <= (count_d != '0);
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
endmodule : bwhp_fifo

module bwhp_host_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic power_down_n,
  input wire logic crystal_select,
  output logic crystal_b_active,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [`BWHP_SEL_W-1:0] register_select,
  input wire logic capture_ack_n,
  input wire logic playback_ack_n,
  input wire logic [`BWHP_BYTE_W-1:0] data_in,
  output logic [`BWHP_BYTE_W-1:0] data_out,
  output logic data_oe,
  output logic capture_request,
  output logic playback_request,
  output logic buffer_enable_n,
  output logic buffer_direction,
  output logic host_interrupt,
  output logic [`BWHP_EXT_W-1:0] external_control_out,
  input wire logic [`BWHP_EXT_W-1:0] ext_control_bits,
  input wire logic dma_underflow,
  input wire logic int_clear,
  input wire logic cap_valid,
  output logic cap_ready,
  input wire logic [`BWHP_SAMPLE_W-1:0] cap_data,
  output logic play_valid,
  input wire logic play_ready,
  output logic [`BWHP_SAMPLE_W-1:0] play_data,
  output logic reg_read,
  output logic reg_write,
  output logic [`BWHP_SEL_W-1:0] reg_index,
  output logic [`BWHP_BYTE_W-1:0] reg_wdata,
  input wire logic [`BWHP_BYTE_W-1:0] reg_rdata
);
  localparam int PIN_W = $bits(bwhp_pkg::bwhp_pins_t);

  bwhp_pkg::bwhp_pins_t pins_raw;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  bwhp_pkg::bwhp_pins_t cur;
  bwhp_pkg::bwhp_pins_t prev_q;
  bwhp_pkg::bwhp_cycle_t cyc_q;
  bwhp_pkg::bwhp_cycle_t cyc_now;
  logic live_b;
  logic start;
  logic finish;
  logic rd_pend_q;
  logic [`BWHP_BIDX_W-1:0] cap_idx_q;
  logic [`BWHP_BIDX_W-1:0] play_idx_q;
  logic fifo_valid;
  logic fifo_pop;
  logic [`BWHP_SAMPLE_W-1:0] fifo_data;

  // decode of a strobe cycle from sampled pins
  function automatic bwhp_pkg::bwhp_cycle_t cycle_of(input bwhp_pkg::bwhp_pins_t p);
    if (!p.rd_n && !p.capture_ack_n)
    begin
      cycle_of = bwhp_pkg::CYC_CAP_RD;
    end
    else if (!p.wr_n && !p.playback_ack_n)
    begin
      cycle_of = bwhp_pkg::CYC_PLAY_WR;
    end
    else if (!p.rd_n && !p.cs_n)
    begin
      cycle_of = bwhp_pkg::CYC_REG_RD;
    end
    else if (!p.wr_n && !p.cs_n)
    begin
      cycle_of = bwhp_pkg::CYC_REG_WR;
    end
    else
    begin
      cycle_of = bwhp_pkg::CYC_IDLE;
    end
  endfunction : cycle_of

  // power down acts as a held reset of the whole port
  assign live_b = rst_b && power_down_n;

  assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, capture_ack_n: capture_ack_n,
                      playback_ack_n: playback_ack_n, register_select: register_select, data: data_in};

  // two-stage synchroniser per pin bit
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (!live_b)
        begin
          pin_s1_q[gi] <= 1'b1;
          pin_s2_q[gi] <= 1'b1;
        end
        else
        begin
          pin_s1_q[gi] <= pins_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate

  assign cur = bwhp_pkg::bwhp_pins_t'(pin_s2_q);
  assign cyc_now = cycle_of(cur);
  assign start = (cyc_q == bwhp_pkg::CYC_IDLE) && (cyc_now != bwhp_pkg::CYC_IDLE) && prev_q.rd_n && prev_q.wr_n;
  assign finish = (cyc_q != bwhp_pkg::CYC_IDLE) && cur.rd_n && cur.wr_n;

  // cycle tracker
  always_ff @(posedge clock)
  begin
    if (!live_b)
    begin
      prev_q <= '1;
      cyc_q <= bwhp_pkg::CYC_IDLE;
    end
    else
    begin
      prev_q <= cur;
      if (start)
      begin
        cyc_q <= cyc_now;
      end
      else if (finish)
      begin
        cyc_q <= bwhp_pkg::CYC_IDLE;
      end
    end
  end

  // transceiver controls
  always_ff @(posedge clock)
  begin
    if (!live_b)
    begin
      buffer_enable_n <= 1'b1;
      buffer_direction <= 1'b1;
    end
    else
    begin
      buffer_enable_n <= !((!cur.rd_n || !cur.wr_n) &&
                           (!cur.cs_n || !cur.capture_ack_n || !cur.playback_ack_n));
      buffer_direction <= !(!cur.rd_n && (!cur.cs_n || !cur.capture_ack_n || !cur.playback_ack_n));
    end
  end

  // read data path and bus drive
  always_ff @(posedge clock)
  begin
    if (!live_b)
    begin
      data_out <= `BWHP_BYTE_ZERO;
      data_oe <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      rd_pend_q <= start && (cyc_now == bwhp_pkg::CYC_REG_RD);
      if (finish)
      begin
        data_oe <= 1'b0;
      end
      else if (rd_pend_q)
      begin
        data_out <= reg_rdata;
        data_oe <= 1'b1;
      end
      else if (start && (cyc_now == bwhp_pkg::CYC_CAP_RD))
      begin
        data_out <= fifo_valid ? fifo_data[cap_idx_q*`BWHP_BYTE_W +: `BWHP_BYTE_W] : `BWHP_BYTE_ZERO;
        data_oe <= 1'b1;
      end
    end
  end

  // programmed register strobes
  always_ff @(posedge clock)
  begin
    if (!live_b)
    begin
      reg_read <= 1'b0;
      reg_write <= 1'b0;
      reg_index <= `BWHP_SEL_ZERO;
      reg_wdata <= `BWHP_BYTE_ZERO;
    end
    else
    begin
      reg_read <= start && (cyc_now == bwhp_pkg::CYC_REG_RD);
      reg_write <= finish && (cyc_q == bwhp_pkg::CYC_REG_WR);
      if (start)
      begin
        reg_index <= cur.register_select;
      end
      if (finish && (cyc_q == bwhp_pkg::CYC_REG_WR))
      begin
        reg_wdata <= prev_q.data;
      end
    end
  end

  // capture byte sequencing
  assign fifo_pop = finish && (cyc_q == bwhp_pkg::CYC_CAP_RD) && fifo_valid && (cap_idx_q == `BWHP_BIDX_LAST);

  always_ff @(posedge clock)
  begin
    if (!live_b)
    begin
      cap_idx_q <= `BWHP_BIDX_ZERO;
      capture_request <= 1'b0;
    end
    else
    begin
      if (finish && (cyc_q == bwhp_pkg::CYC_CAP_RD) && fifo_valid)
      begin
        cap_idx_q <= `BWHP_BIDX_W'(cap_idx_q + `BWHP_BIDX_ONE);
      end
      capture_request <= fifo_valid && !fifo_pop;
    end
  end

  bwhp_fifo #(
    .WIDTH(`BWHP_SAMPLE_W),
    .DEPTH(`BWHP_FIFO_DEPTH)
  ) u_cap_fifo (
    .clock(clock),
    .rst_b(live_b),
    .in_valid(cap_valid),
    .in_ready(cap_ready),
    .in_data(cap_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // playback byte assembly
  always_ff @(posedge clock)
  begin
    if (!live_b)
    begin
      play_idx_q <= `BWHP_BIDX_ZERO;
      play_data <= `BWHP_SAMPLE_ZERO;
      play_valid <= 1'b0;
      playback_request <= 1'b0;
    end
    else
    begin
      if (finish && (cyc_q == bwhp_pkg::CYC_PLAY_WR) && !play_valid)
      begin
        play_data[play_idx_q*`BWHP_BYTE_W +: `BWHP_BYTE_W] <= prev_q.data;
        play_idx_q <= `BWHP_BIDX_W'(play_idx_q + `BWHP_BIDX_ONE);
        if (play_idx_q == `BWHP_BIDX_LAST)
        begin
          play_valid <= 1'b1;
        end
      end
      else if (play_valid && play_ready)
      begin
        play_valid <= 1'b0;
      end
      playback_request <= !play_valid &&
        !(finish && (cyc_q == bwhp_pkg::CYC_PLAY_WR) && (play_idx_q == `BWHP_BIDX_LAST));
    end
  end

  // interrupt, external controls, clock source
  always_ff @(posedge clock)
  begin
    if (!live_b)
    begin
      host_interrupt <= 1'b0;
      external_control_out <= `BWHP_EXT_ZERO;
      crystal_b_active <= 1'b0;
    end
    else
    begin
      if (dma_underflow)
      begin
        host_interrupt <= 1'b1;
      end
      else if (int_clear)
      begin
        host_interrupt <= 1'b0;
      end
      external_control_out <= ext_control_bits;
      crystal_b_active <= crystal_select;
    end
  end
endmodule : bwhp_host_port

// *** dv/bwhp_checker.sv ***
// assertions on the host port pins
`timescale 1ns/10ps
module bwhp_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic power_down_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cs_n,
  input wire logic capture_ack_n,
  input wire logic playback_ack_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic capture_request,
  input wire logic buffer_enable_n,
  input wire logic buffer_direction,
  input wire logic host_interrupt,
  input wire logic [1:0] external_control_out,
  input wire logic [1:0] ext_control_bits,
  input wire logic dma_underflow,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_idle_en; (rd_n && wr_n)[*4] |=> buffer_enable_n; endproperty
  a_idle_en: assert property (p_idle_en) else $error("enable without strobe");
  property p_dir; rd_n[*4] |=> buffer_direction; endproperty
  a_dir: assert property (p_dir) else $error("direction low without read");
  property p_oe; data_oe |-> !buffer_enable_n && !buffer_direction; endproperty
  a_oe: assert property (p_oe) else $error("bus driven outside read");
  property p_rd; reg_read |=> !reg_read && data_oe && data_out == $past(reg_rdata); endproperty
  a_rd: assert property (p_rd) else $error("register read data wrong");
  property p_wr; reg_write |-> !data_oe ##1 !reg_write; endproperty
  a_wr: assert property (p_wr) else $error("register write pulse wrong");
  property p_cap; $fell(capture_request) && $past(power_down_n) |-> !$past(buffer_direction); endproperty
  a_cap: assert property (p_cap) else $error("capture request fell outside read");
  property p_ext; $past(rst_b) && $past(power_down_n) |-> external_control_out == $past(ext_control_bits); endproperty
  a_ext: assert property (p_ext) else $error("external control not mirrored");
  property p_int; dma_underflow && power_down_n |=> host_interrupt; endproperty
  a_int: assert property (p_int) else $error("no interrupt on underflow");
  property p_pd; !power_down_n |=> buffer_enable_n && !data_oe && !capture_request && !host_interrupt; endproperty
  a_pd: assert property (p_pd) else $error("port active in power down");
  property p_act_en;
    ((!rd_n || !wr_n) && (!cs_n || !capture_ack_n || !playback_ack_n) && power_down_n)[*4] |=> !buffer_enable_n;
  endproperty
  a_act_en: assert property (p_act_en) else $error("enable high during qualified strobe");
  property p_act_dir;
    (!rd_n && (!cs_n || !capture_ack_n || !playback_ack_n) && power_down_n)[*4] |=> !buffer_direction;
  endproperty
  a_act_dir: assert property (p_act_dir) else $error("direction high during qualified read");
endmodule : bwhp_checker

// *** dv/bwhp_host_model.sv ***
// host bus and dma controller model
`timescale 1ns/10ps
module bwhp_host_model (
  input wire logic clock,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] register_select,
  output logic capture_ack_n,
  output logic playback_ack_n,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  initial {cs_n, rd_n, wr_n, capture_ack_n, playback_ack_n, register_select, data_in} = 15'h7f00;
  // kinds: 0 reg read, 1 reg write, 2 capture read, 3 playback write, 4 unselected read
  task automatic xfer(input logic [2:0] k, input logic [1:0] s, input logic [7:0] w, input int len,
    output logic [7:0] r);
    @(posedge clock);
    cs_n <= !(k < 3'h2);
    capture_ack_n <= k != 3'h2;
    playback_ack_n <= k != 3'h3;
    register_select <= s;
    data_in <= k[0] ? w : ~data_in;
    @(posedge clock);
    rd_n <= k[0];
    wr_n <= !k[0];
    repeat (len) @(posedge clock);
    // undriven bus reads back as the inverse
    r = data_oe ? data_out : ~data_out;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (7) @(posedge clock);
    {cs_n, capture_ack_n, playback_ack_n} <= 3'h7;
    data_in <= ~data_in;
    repeat (2) @(posedge clock);
  endtask : xfer
endmodule : bwhp_host_model

// *** dv/tb_byte_wide_codec_host_port.sv ***
// testbench of the codec host port
`timescale 1ns/10ps
module tb_byte_wide_codec_host_port;
  logic clock = 0, rst_b = 0, power_down_n = 1, crystal_select = 0, crystal_b_active;
  logic cs_n, rd_n, wr_n, capture_ack_n, playback_ack_n, data_oe, capture_request, playback_request;
  logic buffer_enable_n, buffer_direction, host_interrupt, dma_underflow = 0, int_clear = 0;
  logic cap_valid = 0, cap_ready, play_valid, play_ready = 0, reg_read, reg_write;
  logic [1:0] register_select, external_control_out, ext_control_bits = 0, reg_index, ri;
  logic [7:0] data_in, data_out, reg_wdata, wd, rv, b, reg_rdata;
  logic [31:0] cap_data = 0, play_data;
  int fails = 0, check_count = 0, cyc = 0, rn = 0, n;
  always #4 clock = ~clock;
  bwhp_host_port i_dut (.clock, .rst_b, .power_down_n, .crystal_select, .crystal_b_active, .cs_n, .rd_n,
    .wr_n, .register_select, .capture_ack_n, .playback_ack_n, .data_in, .data_out, .data_oe,
    .capture_request, .playback_request, .buffer_enable_n, .buffer_direction, .host_interrupt,
    .external_control_out, .ext_control_bits, .dma_underflow, .int_clear, .cap_valid, .cap_ready,
    .cap_data, .play_valid, .play_ready, .play_data, .reg_read, .reg_write, .reg_index, .reg_wdata,
    .reg_rdata);
  bwhp_host_model i_host (.clock, .cs_n, .rd_n, .wr_n, .register_select, .capture_ack_n,
    .playback_ack_n, .data_in, .data_out, .data_oe);
  // register file stand-in, contents depend on the index
  assign reg_rdata = 8'h3c ^ {6'h00, reg_index};
  always @(posedge clock)
  begin
    cyc++;
    if (reg_read) rn++;
    if (reg_write) {ri, wd} <= {reg_index, reg_wdata};
    if (cyc == 10000)
    begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) 
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic t_mirror;
    chk({buffer_enable_n, buffer_direction, data_oe}, 3'h6);
    ext_control_bits <= 2'h2;
    crystal_select <= 1'b1;
    repeat (3) @(posedge clock);
    chk(external_control_out, 2'h2);
    chk(crystal_b_active, 1'b1);
  endtask : t_mirror
  task automatic t_regs;
    i_host.xfer(3'h1, 2'h2, 8'ha5, 5, rv);
    chk({ri, wd}, 10'h2a5);
    i_host.xfer(3'h0, 2'h1, 8'h00, 5, rv);
    chk(rv, 8'h3d);
    chk(reg_index, 2'h1);
    n = rn;
    i_host.xfer(3'h4, 2'h0, 8'h00, 5, rv);
    chk(rn, n);
  endtask : t_regs
  task automatic t_capture;
    n = 0;
    cap_valid <= 1'b1;
    repeat (40)
    begin
      b = 8'(n * 4);
      cap_data <= {b + 8'h03, b + 8'h02, b + 8'h01, b};
      @(posedge clock);
      if (cap_ready) n++;
    end
    cap_valid <= 1'b0;
    chk(n, 32);
    for (int i = 0; i < 32; i++)
    begin
      chk(capture_request, 1'b1);
      for (int j = 0; j < 4; j++)
      begin
        i_host.xfer(3'h2, 2'h0, 8'h00, 5 + j, rv);
        chk(rv, 8'(i * 4 + j));
      end
    end
    chk(capture_request, 1'b0);
  endtask : t_capture
  task automatic t_play;
    chk(playback_request, 1'b1);
    for (int j = 0; j < 4; j++) i_host.xfer(3'h3, 2'h0, 8'(16 + j), 5, rv);
    chk({play_valid, playback_request}, 2'h2);
    chk(play_data, 32'h1312_1110);
    play_ready <= 1'b1;
    @(posedge clock);
    play_ready <= 1'b0;
    repeat (2) @(posedge clock);
    chk(play_valid, 1'b0);
    chk(playback_request, 1'b1);
  endtask : t_play
  task automatic t_int;
    dma_underflow <= 1'b1;
    @(posedge clock);
    dma_underflow <= 1'b0;
    repeat (4) @(posedge clock);
    chk(host_interrupt, 1'b1);
    int_clear <= 1'b1;
    @(posedge clock);
    int_clear <= 1'b0;
    dma_underflow <= 1'b1;
    @(posedge clock);
    chk(host_interrupt, 1'b0);
    dma_underflow <= 1'b0;
    power_down_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk({host_interrupt, buffer_enable_n}, 2'h1);
    power_down_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : t_int
  initial
  begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    t_mirror;
    t_regs;
    t_capture;
    t_play;
    t_int;
    test_done;
  end
endmodule : tb_byte_wide_codec_host_port
bind bwhp_host_port bwhp_checker i_chk (.clock, .rst_b, .power_down_n, .rd_n, .wr_n,
  .cs_n, .capture_ack_n, .playback_ack_n, .data_out, .data_oe,
  .capture_request, .buffer_enable_n, .buffer_direction, .host_interrupt, .external_control_out,
  .ext_control_bits, .dma_underflow, .reg_read, .reg_write, .reg_rdata);
